// file: tmr_out_map.svh
// Register offsets, field positions and reset values for the timer output block
`ifndef TMR_OUT_MAP_SVH
`define TMR_OUT_MAP_SVH
`define OFS_TOC      12'h000
`define OFS_PRM      12'h004
`define OFS_RUN      12'h008
`define OFS_STAT     12'h00C
`define OFS_MASK     12'h010
`define OFS_EVT      12'h014
// Output control field positions
`define TOC_INV_PRI  0
`define TOC_LVR      2
`define TOC_LVS      3
`define TOC_INV_SEC  4
`define TOC_OSPE     5
`define TOC_OSPT     6
`define TOC_TOE      0
// Prescaler field positions
`define PRM_CKS_LO   0
`define PRM_CKS_HI   1
`define PRM_ES0_LO   4
`define PRM_ES0_HI   5
`define PRM_ES1_LO   6
`define PRM_ES1_HI   7
// Status bits and register reset values
`define ST_EDGE0     0
`define ST_EDGE1     1
`define ST_SHOT      2
`define TOC_RST      8'h00
`define PRM_RST      8'h00
`endif

// file: tmr_out_pkg.sv
// Types shared by the timer output block
package tmr_out_pkg;
    typedef enum logic [1:0]
    {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;
    typedef enum logic [2:0]
    {
        SHOT_IDLE = 3'h1,
        SHOT_ARM  = 3'h2,
        SHOT_HOLD = 3'h4
    } shot_state_t;
endpackage

// file: edge_detect.sv
// Synchronised edge detector for one timer edge input
`timescale 1ns/10ps
`default_nettype none
module edge_detect
    import tmr_out_pkg::*;
(
    input  wire logic      clk_in,
    input  wire logic      rst_in,
    input  wire logic      pin_in,
    input  wire logic      sample_in,
    input  wire logic      run_in,
    input  wire logic      en_in,
    input  wire logic [1:0] sel_in,
    output logic           edge_out
);
    logic sync1_q, sync2_q, samp_q, prev_q, first_q, run_q, edge_q;
    logic samp_d, prev_d, first_d, edge_d;
    logic rise, fall;

    // Next-state: sample on noise clock strobe, track enable history
    always_comb
    begin
        samp_d  = sample_in ? sync2_q : samp_q;
        prev_d  = samp_q;
        first_d = first_q;
        if (run_in && !run_q)
        begin
            // First enable after reset sees reset level low; later no edge
            prev_d  = first_q ? 1'b0 : samp_q;
            first_d = 1'b0;
        end
        rise   = samp_q && !prev_q;
        fall   = !samp_q && prev_q;
        edge_d = 1'b0;
        if (run_q && en_in)
        begin
            case (sel_in)
                EDGE_FALL: edge_d = fall;
                EDGE_RISE: edge_d = rise;
                EDGE_BOTH: edge_d = rise | fall;
                default:   edge_d = 1'b0;
            endcase
        end
    end

    // Registers, synchroniser first stage read only by second
    always_ff @(posedge clk_in)
    begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
        if (rst_in)
        begin
            samp_q  <= 1'b0;
            prev_q  <= 1'b0;
            first_q <= 1'b1;
            run_q   <= 1'b0;
            edge_q  <= 1'b0;
        end
        else
        begin
            samp_q  <= samp_d;
            prev_q  <= prev_d;
            first_q <= first_d;
            run_q   <= run_in;
            edge_q  <= edge_d;
        end
    end
    assign edge_out = edge_q;
endmodule
`default_nettype wire

// file: tmr_out_ctrl.sv
// Timer output flip-flop, one-shot trigger, prescaler and edge control
`include "tmr_out_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tmr_out_ctrl
    import tmr_out_pkg::*;
#(
    parameter int DIV_W = 4
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        int_osc_sel_in,
    input  wire logic        first_edge_input_in,
    input  wire logic        shared_port_pin_in,
    input  wire logic        primary_match_in,
    input  wire logic        secondary_match_in,
    output logic             shared_port_pin_out,
    output logic             shared_port_pin_oe_out,
    output logic             count_tick_out,
    output logic             one_shot_start_out,
    output logic             first_edge_out,
    output logic             second_edge_out,
    output logic             irq_out
);
    logic [7:0] toc_q, toc_d, prm_q, prm_d;
    logic       toe_q, toe_d, run_q, run_d, ff_q, ff_d;
    logic       ready_q, ready_d, err_q, err_d, irq_q, irq_d;
    logic       shot_q, shot_d, tick_q, tick_d;
    logic [2:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [1:0] oscdiv_q, oscdiv_d;
    shot_state_t st_q, st_d;
    logic       wr, rd, acc, e0, e1, sample, tick, sec_edge_en, oscstb;

    assign acc = psel && penable && !ready_q;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;

    // Prescaler: slower clock source when CPU runs on internal oscillator
    always_comb
    begin
        oscdiv_d = oscdiv_q + 2'h1;
        oscstb   = (oscdiv_q == 2'h3);
        sample   = int_osc_sel_in ? oscstb : 1'b1;
        div_d    = int_osc_sel_in ? (oscstb ? div_q + 1'b1 : div_q)
                                  : div_q + 1'b1;
        case (prm_q[`PRM_CKS_HI:`PRM_CKS_LO])
            2'h0:    tick = sample;
            2'h1:    tick = div_q[0] && (sample || !int_osc_sel_in);
            2'h2:    tick = (div_q[1:0] == 2'h3) && sample;
            default: tick = e0;
        endcase
        tick_d = run_q && tick;
    end

    // Shared pin: output wins, second input edge only when output is off
    assign sec_edge_en = !toe_q;

    edge_detect u_edge0
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (first_edge_input_in),
        .sample_in (sample),
        .run_in    (run_q),
        .en_in     (1'b1),
        .sel_in    (prm_q[`PRM_ES0_HI:`PRM_ES0_LO]),
        .edge_out  (e0)
    );
    edge_detect u_edge1
    (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (shared_port_pin_in),
        .sample_in (sample),
        .run_in    (run_q),
        .en_in     (sec_edge_en),
        .sel_in    (prm_q[`PRM_ES1_HI:`PRM_ES1_LO]),
        .edge_out  (e1)
    );

    // Register writes, output flip-flop, one-shot and interrupt state
    always_comb
    begin
        toc_d   = toc_q;
        prm_d   = prm_q;
        toe_d   = toe_q;
        run_d   = run_q;
        mask_d  = mask_q;
        ff_d    = ff_q;
        st_d    = st_q;
        shot_d  = 1'b0;
        ready_d = acc;
        err_d   = 1'b0;
        rdata_d = 32'h0;
        // Trigger and level bits self-clear: never stored across a cycle
        toc_d[`TOC_OSPT] = 1'b0;
        toc_d[`TOC_LVS]  = 1'b0;
        toc_d[`TOC_LVR]  = 1'b0;
        // Inversion on compare matches while output runs
        if (run_q && toe_q)
        begin
            if ((primary_match_in && toc_q[`TOC_INV_PRI]) ^
                (secondary_match_in && toc_q[`TOC_INV_SEC]))
                ff_d = !ff_q;
        end
        case (st_q)
            SHOT_IDLE: st_d = SHOT_IDLE;
            SHOT_ARM:
            begin
                shot_d = 1'b1;
                st_d   = SHOT_HOLD;
            end
            SHOT_HOLD: st_d = tick_q ? SHOT_IDLE : SHOT_HOLD;
            default:   st_d = SHOT_IDLE;
        endcase
        if (wr)
        begin
            case (paddr)
                `OFS_TOC:
                begin
                    toc_d = pwdata[7:0];
                    toc_d[`TOC_LVS]  = 1'b0;
                    toc_d[`TOC_LVR]  = 1'b0;
                    toc_d[`TOC_OSPT] = 1'b0;
                    if (pwdata[`TOC_LVS])
                        ff_d = 1'b1;
                    else if (pwdata[`TOC_LVR])
                        ff_d = 1'b0;
                    // Ignore triggers outside one-shot mode or too soon
                    if (pwdata[`TOC_OSPT] && toc_q[`TOC_OSPE] &&
                        st_q == SHOT_IDLE)
                        st_d = SHOT_ARM;
                end
                `OFS_PRM:  prm_d = pwdata[7:0];
                `OFS_RUN:
                begin
                    run_d = pwdata[0];
                    toe_d = pwdata[1];
                end
                `OFS_MASK: mask_d = pwdata[2:0];
                `OFS_STAT: ;
                default:   err_d = 1'b1;
            endcase
        end
        if (rd)
        begin
            case (paddr)
                `OFS_TOC:  rdata_d = {24'h0, toc_q};
                `OFS_PRM:  rdata_d = {24'h0, prm_q};
                `OFS_RUN:  rdata_d = {30'h0, toe_q, run_q};
                `OFS_STAT: rdata_d = {29'h0, stat_q};
                `OFS_MASK: rdata_d = {29'h0, mask_q};
                `OFS_EVT:  rdata_d = {31'h0, ff_q};
                default:   err_d = 1'b1;
            endcase
        end
        // Sticky status: set wins over write-one-to-clear
        stat_d = stat_q;
        if (wr && paddr == `OFS_STAT)
            stat_d = stat_q & ~pwdata[2:0];
        stat_d = stat_d | {shot_q, e1, e0};
        irq_d  = |(stat_d & mask_d);
    end

    // State registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            toc_q    <= `TOC_RST;
            prm_q    <= `PRM_RST;
            toe_q    <= 1'b0;
            run_q    <= 1'b0;
            ff_q     <= 1'b0;
            st_q     <= SHOT_IDLE;
            shot_q   <= 1'b0;
            tick_q   <= 1'b0;
            stat_q   <= 3'h0;
            mask_q   <= 3'h0;
            irq_q    <= 1'b0;
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
            rdata_q  <= 32'h0;
            div_q    <= '0;
            oscdiv_q <= 2'h0;
        end
        else
        begin
            toc_q    <= toc_d;
            prm_q    <= prm_d;
            toe_q    <= toe_d;
            run_q    <= run_d;
            ff_q     <= ff_d;
            st_q     <= st_d;
            shot_q   <= shot_d;
            tick_q   <= tick_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            irq_q    <= irq_d;
            ready_q  <= ready_d;
            err_q    <= err_d;
            rdata_q  <= rdata_d;
            div_q    <= div_d;
            oscdiv_q <= oscdiv_d;
        end
    end

    // Outputs all come from flops; pin driven only when output enabled
    assign pready                 = ready_q;
    assign pslverr                = err_q;
    assign prdata                 = rdata_q;
    assign shared_port_pin_out    = ff_q;
    assign shared_port_pin_oe_out = toe_q;
    assign count_tick_out         = tick_q;
    assign one_shot_start_out     = shot_q;
    assign first_edge_out         = stat_q[`ST_EDGE0];
    assign second_edge_out        = stat_q[`ST_EDGE1];
    assign irq_out                = irq_q;

    chk_lvl_readzero: assert property (@(posedge clk_in) disable iff (rst_in)
        !toc_q[`TOC_LVS] && !toc_q[`TOC_LVR])
        else $error("level bits stored");
    chk_trig_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        !toc_q[`TOC_OSPT])
        else $error("trigger stored");
    chk_lvs_high: assert property (@(posedge clk_in) disable iff (rst_in)
        wr && paddr == `OFS_TOC && pwdata[`TOC_LVS] |=> ff_q)
        else $error("set did not force high");
    chk_lvr_low: assert property (@(posedge clk_in) disable iff (rst_in)
        wr && paddr == `OFS_TOC && !pwdata[`TOC_LVS] && pwdata[`TOC_LVR]
        |=> !ff_q)
        else $error("reset did not force low");
    chk_pin_excl: assert property (@(posedge clk_in) disable iff (rst_in)
        shared_port_pin_oe_out |-> ##2 !e1)
        else $error("edge while output");
    chk_shot_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
        st_q == SHOT_ARM |=> shot_q ##1 !shot_q)
        else $error("one-shot start not one cycle");
    chk_tick_stop: assert property (@(posedge clk_in) disable iff (rst_in)
        !run_q |=> !tick_q)
        else $error("tick while stopped");
    chk_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(stat_q[0]) && mask_q[0] |-> irq_q)
        else $error("irq missing");
endmodule
`default_nettype wire

// file: tmr_pin_model.sv
// Pin-side model: drives both edge inputs and resolves the shared pin
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model
(
    input  wire logic first_lvl_in,
    input  wire logic second_lvl_in,
    input  wire logic second_drv_in,
    input  wire logic pin_data_in,
    input  wire logic pin_oe_in,
    output logic      first_pin_out,
    output logic      shared_pin_out
);
    // Timer output owns the pin while enabled; otherwise the second driver wins, and the pull-up only when it is off
    always_comb
    begin
        first_pin_out = first_lvl_in;
        if (pin_oe_in)
            shared_pin_out = pin_data_in;
        else if (second_drv_in)
            shared_pin_out = second_lvl_in;
        else
            shared_pin_out = 1'b1;
    end
endmodule
`default_nettype wire

// file: tmr_out_ctrl_bench.sv
// Self-checking bench for the timer output and prescaler control block
`include "tmr_out_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tmr_out_ctrl_bench;
    logic        clk_in;
    logic        rst_in;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        int_osc;
    logic        first_pin;
    logic        shared_pin;
    logic        pri_match;
    logic        sec_match;
    logic        pin_q;
    logic        pin_oe;
    logic        tick;
    logic        shot;
    logic        edge1;
    logic        edge2;
    logic        irq;
    logic        first_lvl;
    logic        second_lvl;
    logic        second_drv;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] shots;
    int          miscompares;
    int          checked;
    int          cyc;

    tmr_out_ctrl #(.DIV_W(4)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .int_osc_sel_in(int_osc),
        .first_edge_input_in(first_pin), .shared_port_pin_in(shared_pin),
        .primary_match_in(pri_match), .secondary_match_in(sec_match),
        .shared_port_pin_out(pin_q), .shared_port_pin_oe_out(pin_oe),
        .count_tick_out(tick), .one_shot_start_out(shot),
        .first_edge_out(edge1), .second_edge_out(edge2), .irq_out(irq));

    tmr_pin_model pins (.first_lvl_in(first_lvl), .second_lvl_in(second_lvl),
        .second_drv_in(second_drv), .pin_data_in(pin_q),
        .pin_oe_in(pin_oe), .first_pin_out(first_pin),
        .shared_pin_out(shared_pin));

    // 200 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Hang guard and one-shot pulse counter
    always @(posedge clk_in)
    begin
        cyc++;
        if (shot === 1'b1)
            shots <= shots + 32'h1;
        if (cyc == 20000)
        begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // One APB transfer; pready is sampled at rising edges only
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            miscompares++;
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask

    // Bounded wait for a status level to rise
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 60)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask

    // Cycles between two count ticks
    task automatic gap(input logic [31:0] exp);
        int n;
        wait_hi(tick);
        @(negedge clk_in);
        n = 1;
        while (tick !== 1'b1 && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        check(32'(n), exp);
    endtask

    task automatic t_reset();
        rd(`OFS_TOC, 32'h0);
        rd(`OFS_PRM, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check({31'h0, pin_oe}, 32'h0);
    endtask

    task automatic t_edges();
        wr(`OFS_PRM, 32'h90);
        wr(`OFS_STAT, 32'h7);
        wr(`OFS_RUN, 32'h1);
        wait_hi(edge1);
        check({31'h0, edge1}, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(`OFS_MASK, 32'h1);
        wt(2);
        check({31'h0, irq}, 32'h1);
        wr(`OFS_STAT, 32'h1);
        wt(2);
        check({31'h0, irq}, 32'h0);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_RUN, 32'h1);
        wt(40);
        check({31'h0, edge1}, 32'h0);
        @(posedge clk_in);
        first_lvl <= 1'b0;
        wt(30);
        @(posedge clk_in);
        first_lvl <= 1'b1;
        wait_hi(edge1);
        check({31'h0, edge1}, 32'h1);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_MASK, 32'h0);
    endtask

    task automatic t_level();
        wr(`OFS_RUN, 32'h2);
        wr(`OFS_TOC, 32'h1);
        wr(`OFS_TOC, 32'h9);
        wt(2);
        check({31'h0, pin_q}, 32'h1);
        check({31'h0, pin_oe}, 32'h1);
        rd(`OFS_TOC, 32'h1);
        rd(`OFS_EVT, 32'h1);
        wr(`OFS_TOC, 32'h5);
        wt(2);
        check({31'h0, pin_q}, 32'h0);
        rd(`OFS_TOC, 32'h1);
        wr(`OFS_RUN, 32'h0);
    endtask

    task automatic t_shared();
        wr(`OFS_PRM, 32'h60);
        second_drv <= 1'b1;
        wr(`OFS_STAT, 32'h7);
        wr(`OFS_RUN, 32'h1);
        wt(20);
        @(posedge clk_in);
        second_lvl <= 1'b1;
        wait_hi(edge2);
        check({31'h0, edge2}, 32'h1);
        wr(`OFS_RUN, 32'h0);
        second_drv <= 1'b0;
        wr(`OFS_STAT, 32'h2);
        wr(`OFS_RUN, 32'h2);
        wr(`OFS_TOC, 32'h5);
        wr(`OFS_RUN, 32'h3);
        wt(20);
        @(posedge clk_in);
        pri_match <= 1'b1;
        @(posedge clk_in);
        pri_match <= 1'b0;
        wt(40);
        check({31'h0, shared_pin}, 32'h1);
        check({31'h0, edge2}, 32'h0);
        wr(`OFS_RUN, 32'h0);
    endtask

    task automatic t_shot();
        wr(`OFS_PRM, 32'hA0);
        wr(`OFS_TOC, 32'h20);
        wr(`OFS_STAT, 32'h7);
        wr(`OFS_MASK, 32'h4);
        wr(`OFS_RUN, 32'h1);
        shots <= 32'h0;
        wr(`OFS_TOC, 32'h60);
        wt(20);
        check(shots, 32'h1);
        rd(`OFS_TOC, 32'h20);
        check({31'h0, irq}, 32'h1);
        wr(`OFS_STAT, 32'h4);
        wt(2);
        check({31'h0, irq}, 32'h0);
        wt(4);
        wr(`OFS_TOC, 32'h60);
        wt(20);
        check(shots, 32'h2);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_TOC, 32'h0);
    endtask

    // Duty change: secondary inversion off, then back on after an ignored secondary match
    task automatic t_duty();
        wr(`OFS_RUN, 32'h2);
        wr(`OFS_TOC, 32'h10);
        wr(`OFS_TOC, 32'h14);
        wr(`OFS_RUN, 32'h3);
        wr(`OFS_TOC, 32'h00);
        wr(`OFS_MASK, 32'h0);
        @(posedge clk_in);
        sec_match <= 1'b1;
        @(posedge clk_in);
        sec_match <= 1'b0;
        wt(4);
        check({31'h0, pin_q}, 32'h0);
        wr(`OFS_TOC, 32'h10);
        @(posedge clk_in);
        sec_match <= 1'b1;
        @(posedge clk_in);
        sec_match <= 1'b0;
        wt(4);
        check({31'h0, pin_q}, 32'h1);
        wr(`OFS_STAT, 32'h7);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_TOC, 32'h0);
    endtask

    task automatic t_prescale();
        wr(`OFS_PRM, 32'hA2);
        wr(`OFS_RUN, 32'h1);
        gap(32'h4);
        wr(`OFS_RUN, 32'h0);
        @(posedge clk_in);
        int_osc <= 1'b1;
        wr(`OFS_PRM, 32'hA0);
        wr(`OFS_RUN, 32'h1);
        gap(32'h4);
        wr(`OFS_RUN, 32'h0);
    endtask

    // Main sequence: pins start high to expose the first-enable edge
    initial
    begin
        miscompares = 0;
        checked = 0;
        cyc = 0;
        rst_in = 1'b1;
        {psel, penable, pwrite, int_osc, pri_match} = 5'h0;
        sec_match = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        first_lvl = 1'b1;
        second_lvl = 1'b0;
        second_drv = 1'b0;
        shots = 32'h0;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_edges();
        t_level();
        t_shared();
        t_shot();
        t_duty();
        t_prescale();
        test_done();
    end
endmodule
`default_nettype wire
